/* design/aux_mux_pkg.sv */
// Shared constants and types for the auxiliary pin function selector
`default_nettype none

package aux_mux_pkg;

	// Pin count and the UART-time GPIO allowance
	localparam int NUM_PINS = 11;
	localparam int GPIO_UART_PINS = 4;

	// Per-pin configuration word layout
	localparam int FN_LSB = 0;
	localparam int FN_W = 4;
	localparam int INV_BIT = 4;
	localparam int DRV_LSB = 5;
	localparam int DRV_W = 2;
	localparam int CFG_W = 7;

	// Pin functions, in configuration code order
	typedef enum logic [3:0] {
		PIN_RS485_EN,
		PIN_POWER_ALLOW,
		PIN_TX_LED,
		PIN_RX_LED,
		PIN_ANY_LED,
		PIN_SLEEP,
		PIN_CLK_FAST,
		PIN_CLK_HALF,
		PIN_CLK_QUARTER,
		PIN_UNUSED,
		PIN_DRIVE_HIGH,
		PIN_DRIVE_LOW,
		PIN_GPIO
	} pin_fn_t;

	// Reset values
	localparam logic [CFG_W-1:0] CFG_RESET = {3'h0, PIN_UNUSED};
	localparam logic [NUM_PINS-1:0] GPIO_RESET = 11'h000;

	// Register byte offsets
	localparam logic [7:0] OFF_PIN_CFG = 8'h00;
	localparam logic [7:0] OFF_GPIO_OUT = 8'h2c;
	localparam logic [7:0] OFF_GPIO_DIR = 8'h30;
	localparam logic [7:0] OFF_GPIO_IN = 8'h34;
	localparam logic [7:0] OFF_STATUS = 8'h38;

	// Status register bit positions
	localparam int ST_SUSPEND = 0;
	localparam int ST_UART = 1;
	localparam int ST_TX_BUSY = 2;

	// Clock rates and the phase accumulator for the fast clock output
	localparam int CLK_MHZ = 200;
	localparam int FAST_CLK_MHZ = 30;
	localparam logic [7:0] CLK_ACC_STEP = 8'(2 * FAST_CLK_MHZ);
	localparam logic [7:0] CLK_ACC_MOD = 8'(CLK_MHZ);

	// Activity indication minimum width
	localparam int LED_CNT_W = 24;
	localparam int LED_PULSE_US = 10000;
	localparam logic [LED_CNT_W-1:0] LED_PULSE_CYCLES = 24'(LED_PULSE_US * CLK_MHZ);

endpackage

`default_nettype wire

/* design/act_if.sv */
// Activity event and stretched indication between mux and stretcher
`timescale 1ns/1ps
`default_nettype none

interface act_if;
	logic trig;
	logic active;
	modport source (output trig, input active);
	modport stretcher (input trig, output active);
endinterface

`default_nettype wire

/* design/led_stretch.sv */
// Retriggerable stretcher that widens activity events for an LED
`timescale 1ns/1ps
`default_nettype none

module led_stretch
	import aux_mux_pkg::*;
#(
	parameter logic [LED_CNT_W-1:0] PULSE_CYCLES = LED_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Event in, indication out
	act_if.stretcher link
);

	logic [LED_CNT_W-1:0] cnt;

	// Reload on every event, then count down to idle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
		end else if (link.trig) begin
			cnt <= PULSE_CYCLES; // [RL17]
		end else if (cnt != '0) begin
			cnt <= cnt - 24'h1;
		end
	end

	// Indication stays on for the whole stretch
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			link.active <= 1'b0;
		end else begin
			link.active <= link.trig || (cnt > 24'h1); // [RL17]
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_pulse_starts;
		link.trig |=> link.active ##1 (link.active || cnt == '0);
	endproperty
	a_pulse_starts: assert property (p_pulse_starts) else $error("stretch did not start"); // [RL17]

	property p_pulse_ends;
		(!link.trig && cnt == 24'h1) |=> !link.active && cnt == '0;
	endproperty
	a_pulse_ends: assert property (p_pulse_ends) else $error("stretch did not end"); // [RL17]

endmodule

`default_nettype wire

/* design/aux_pin_function_mux.sv */
// Function selector for the eleven auxiliary control bus pins
// Behaviour
// RL1: Eleven auxiliary pins, each set independently to one supported function.
// RL2: Each pin's function comes from loaded configuration bits, not pin activity.
// RL3: RS485 enable pin is active exactly while the UART transmits.
// RL4: Power pin tells board whether high-power circuitry may draw full current.
// RL5: Power pin reads 0 in normal operation, 1 while USB is suspended.
// RL6: Transmit LED pin, active low, pulses on each transmission.
// RL7: Receive LED pin, active low, pulses on each reception.
// RL8: Combined LED pin pulses on transmission or reception.
// RL9: Sleep pin, active low, asserts when the device enters USB suspend.
// RL10: Clock pins output continuous 30, 15 or 7.5 MHz as configured.
// RL11: Unused pin is not driven and acts as a pulled-up input.
// RL12: Constant-high pin drives 1, constant-low pin drives 0, continuously.
// RL13: Bit-bang pin is GPIO; direction and value come from host commands.
// RL14: Any pin may individually be GPIO, like asynchronous bit-bang.
// RL15: While the UART runs, up to four pins still work as GPIO.
// RL16: Per-pin output inversion and selectable drive strength.
// RL17: Activity pulses are stretched to a fixed minimum visible width.
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module aux_pin_function_mux
	import aux_mux_pkg::*;
#(
	parameter logic [LED_CNT_W-1:0] LED_PULSE = LED_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Avalon-MM register slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core status
	input wire logic uart_active,
	input wire logic uart_tx_busy,
	input wire logic tx_data_strobe,
	input wire logic rx_data_strobe,
	input wire logic usb_suspend,
	// Auxiliary control bus pins
	input wire logic [NUM_PINS-1:0] aux_in,
	output logic [NUM_PINS-1:0] aux_out,
	output logic [NUM_PINS-1:0] aux_oe,
	output logic [NUM_PINS-1:0] aux_pull_up,
	output logic [2*NUM_PINS-1:0] aux_drive
);

	// Merge a bus write into an old word under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old_word,
		input logic [31:0] new_word, input logic [3:0] be);
		logic [31:0] res;
		res = old_word;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_word[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Function code field of one pin configuration word
	function automatic pin_fn_t pin_fn(input logic [CFG_W-1:0] cfg_word);
		return pin_fn_t'(cfg_word[FN_LSB +: FN_W]);
	endfunction

	logic [CFG_W-1:0] pin_cfg [NUM_PINS];
	logic [NUM_PINS-1:0] gpio_out;
	logic [NUM_PINS-1:0] gpio_dir;
	logic [NUM_PINS-1:0] aux_meta;
	logic [NUM_PINS-1:0] aux_sync;
	logic [31:0] rd_word;
	logic [31:0] wr_word;
	logic pin_hit;
	logic [3:0] pin_idx;
	logic [7:0] clk_acc;
	logic [7:0] next_acc;
	logic clk_fast;
	logic clk_half;
	logic clk_quarter;
	logic [NUM_PINS-1:0] next_out;
	logic [NUM_PINS-1:0] next_oe;
	logic [NUM_PINS-1:0] next_pu;

	act_if tx_if ();
	act_if rx_if ();
	act_if any_if ();

	// Pin inputs cross into the clock domain through two flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aux_meta <= '0;
			aux_sync <= '0;
		end else begin
			aux_meta <= aux_in;
			aux_sync <= aux_meta;
		end
	end

	// Address decode and read word for the current request
	always_comb begin
		rd_word = 32'h0;
		pin_hit = 1'b0;
		pin_idx = avs_address[5:2];
		if (avs_address[1:0] == 2'h0 && avs_address < OFF_GPIO_OUT) begin
			pin_hit = 1'b1;
			rd_word = {25'h0, pin_cfg[pin_idx]};
		end else begin
			case (avs_address)
				OFF_GPIO_OUT: rd_word = {21'h0, gpio_out};
				OFF_GPIO_DIR: rd_word = {21'h0, gpio_dir};
				OFF_GPIO_IN: rd_word = {21'h0, aux_sync};
				OFF_STATUS: rd_word = {29'h0, uart_tx_busy, uart_active, usb_suspend};
				default: rd_word = 32'h0;
			endcase
		end
		wr_word = be_merge(rd_word, avs_writedata, avs_byteenable);
	end

	// One wait cycle per request, then a single cycle with waitrequest low
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Read data is captured in the wait cycle and held through the answer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_word;
		end
	end

	// Pin function words, loaded from configuration memory over the bus
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				pin_cfg[i] <= CFG_RESET;
			end
		end else if (avs_write && !avs_waitrequest && pin_hit) begin
			pin_cfg[pin_idx] <= wr_word[CFG_W-1:0]; // [RL1] [RL2] [RL16]
		end
	end

	// Host bit-bang value and direction
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gpio_out <= GPIO_RESET;
			gpio_dir <= GPIO_RESET;
		end else if (avs_write && !avs_waitrequest) begin
			if (avs_address == OFF_GPIO_OUT) begin
				gpio_out <= wr_word[NUM_PINS-1:0]; // [RL13]
			end
			if (avs_address == OFF_GPIO_DIR) begin
				gpio_dir <= wr_word[NUM_PINS-1:0]; // [RL13]
			end
		end
	end

	// Phase accumulator: the fast clock toggles 60 million times a second
	assign next_acc = clk_acc + CLK_ACC_STEP;

	// Fast, half and quarter clocks; each slower one toggles on a rising edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clk_acc <= 8'h0;
			clk_fast <= 1'b0;
			clk_half <= 1'b0;
			clk_quarter <= 1'b0;
		end else if (next_acc >= CLK_ACC_MOD) begin
			clk_acc <= next_acc - CLK_ACC_MOD;
			clk_fast <= !clk_fast; // [RL10]
			if (!clk_fast) begin
				clk_half <= !clk_half; // [RL10]
				if (!clk_half) begin
					clk_quarter <= !clk_quarter; // [RL10]
				end
			end
		end else begin
			clk_acc <= next_acc;
		end
	end

	// Activity events feed the three stretchers
	assign tx_if.trig = tx_data_strobe; // [RL6]
	assign rx_if.trig = rx_data_strobe; // [RL7]
	assign any_if.trig = tx_data_strobe || rx_data_strobe; // [RL8]

	led_stretch #(.PULSE_CYCLES(LED_PULSE)) u_tx_stretch (
		.mclk(mclk),
		.rst(rst),
		.link(tx_if.stretcher)
	);

	led_stretch #(.PULSE_CYCLES(LED_PULSE)) u_rx_stretch (
		.mclk(mclk),
		.rst(rst),
		.link(rx_if.stretcher)
	);

	led_stretch #(.PULSE_CYCLES(LED_PULSE)) u_any_stretch (
		.mclk(mclk),
		.rst(rst),
		.link(any_if.stretcher)
	);

	// Per-pin function select, inversion applied last
	always_comb begin
		pin_fn_t fn;
		logic val;
		fn = PIN_UNUSED;
		val = 1'b0;
		next_out = '0;
		next_oe = '0;
		next_pu = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			fn = pin_fn(pin_cfg[i]);
			val = 1'b0;
			next_oe[i] = 1'b1;
			next_pu[i] = 1'b0;
			unique case (fn)
				PIN_RS485_EN: val = uart_tx_busy; // [RL3]
				PIN_POWER_ALLOW: val = usb_suspend; // [RL4] [RL5]
				PIN_TX_LED: val = !tx_if.active; // [RL6]
				PIN_RX_LED: val = !rx_if.active; // [RL7]
				PIN_ANY_LED: val = !any_if.active; // [RL8]
				PIN_SLEEP: val = !usb_suspend; // [RL9]
				PIN_CLK_FAST: val = clk_fast; // [RL10]
				PIN_CLK_HALF: val = clk_half; // [RL10]
				PIN_CLK_QUARTER: val = clk_quarter; // [RL10]
				PIN_DRIVE_HIGH: val = 1'b1; // [RL12]
				PIN_DRIVE_LOW: val = 1'b0; // [RL12]
				PIN_GPIO: begin
					if (uart_active && i >= GPIO_UART_PINS) begin
						next_oe[i] = 1'b0; // [RL15]
						next_pu[i] = 1'b1;
					end else begin
						next_oe[i] = gpio_dir[i]; // [RL13] [RL14]
						next_pu[i] = !gpio_dir[i];
						val = gpio_out[i];
					end
				end
				default: begin
					next_oe[i] = 1'b0; // [RL11]
					next_pu[i] = 1'b1;
				end
			endcase
			next_out[i] = val ^ pin_cfg[i][INV_BIT]; // [RL16]
		end
	end

	// Pin outputs and drive strength come straight from flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aux_out <= '0;
			aux_oe <= '0;
			aux_pull_up <= '1;
			aux_drive <= '0;
		end else begin
			aux_out <= next_out;
			aux_oe <= next_oe;
			aux_pull_up <= next_pu;
			for (int i = 0; i < NUM_PINS; i++) begin
				aux_drive[DRV_W*i +: DRV_W] <= pin_cfg[i][DRV_LSB +: DRV_W]; // [RL16]
			end
		end
	end

	// Configuration views of the pins that the checks below watch
	pin_fn_t fn0;
	pin_fn_t fn1;
	pin_fn_t fn4;
	pin_fn_t fn5;
	pin_fn_t fn6;
	pin_fn_t fn7;
	logic inv0;
	logic inv1;
	logic inv4;
	logic inv6;
	logic inv7;
	assign fn0 = pin_fn(pin_cfg[0]);
	assign fn1 = pin_fn(pin_cfg[1]);
	assign fn4 = pin_fn(pin_cfg[4]);
	assign fn5 = pin_fn(pin_cfg[5]);
	assign fn6 = pin_fn(pin_cfg[6]);
	assign fn7 = pin_fn(pin_cfg[7]);
	assign inv0 = pin_cfg[0][INV_BIT];
	assign inv1 = pin_cfg[1][INV_BIT];
	assign inv4 = pin_cfg[4][INV_BIT];
	assign inv6 = pin_cfg[6][INV_BIT];
	assign inv7 = pin_cfg[7][INV_BIT];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_bus_answer;
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");

	property p_drive_high;
		(fn0 == PIN_DRIVE_HIGH && !inv0) |=> aux_out[0] && aux_oe[0];
	endproperty
	a_drive_high: assert property (p_drive_high) else $error("constant high pin not high"); // [RL12]

	property p_drive_low;
		(fn1 == PIN_DRIVE_LOW && !inv1) |=> !aux_out[1] && aux_oe[1];
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("constant low pin not low"); // [RL12]

	property p_unused;
		(fn0 == PIN_UNUSED) |=> !aux_oe[0] && aux_pull_up[0];
	endproperty
	a_unused: assert property (p_unused) else $error("unused pin driven"); // [RL11]

	property p_power;
		(fn4 == PIN_POWER_ALLOW && !inv4) |=> aux_out[4] == $past(usb_suspend);
	endproperty
	a_power: assert property (p_power) else $error("power pin wrong level"); // [RL5]

	property p_rs485;
		(fn6 == PIN_RS485_EN && !inv6) |=> aux_out[6] == $past(uart_tx_busy);
	endproperty
	a_rs485: assert property (p_rs485) else $error("rs485 enable not following uart"); // [RL3]

	property p_tx_led;
		(fn7 == PIN_TX_LED && !inv7 && tx_data_strobe) ##1 (fn7 == PIN_TX_LED && !inv7)
			|=> !aux_out[7];
	endproperty
	a_tx_led: assert property (p_tx_led) else $error("tx led did not pulse low"); // [RL6]

	property p_gpio_limit;
		(fn5 == PIN_GPIO && uart_active) |=> !aux_oe[5];
	endproperty
	a_gpio_limit: assert property (p_gpio_limit) else $error("gpio above limit driven in uart"); // [RL15]

	property p_gpio_drive;
		(fn0 == PIN_GPIO && !inv0 && gpio_dir[0]) |=> aux_oe[0] && aux_out[0] == $past(gpio_out[0]);
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("gpio pin not following host"); // [RL13]

	property p_clk_fast_runs;
		!clk_fast |-> ##[1:4] clk_fast;
	endproperty
	a_clk_fast_runs: assert property (p_clk_fast_runs) else $error("fast clock stalled"); // [RL10]

endmodule

`default_nettype wire

/* testbench/aux_board_model.sv */
// Board side of the auxiliary pins: resolves each pin level
`timescale 1ns/1ps
`default_nettype none

module aux_board_model
	import aux_mux_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Device pin drivers
	input wire logic [NUM_PINS-1:0] aux_out,
	input wire logic [NUM_PINS-1:0] aux_oe,
	input wire logic [NUM_PINS-1:0] aux_pull_up,
	// Board logic driving pins
	input wire logic [NUM_PINS-1:0] ext_en,
	input wire logic [NUM_PINS-1:0] ext_val,
	// Resolved pin levels
	output logic [NUM_PINS-1:0] pin_level
);
	logic [NUM_PINS-1:0] last;

	// A floating pin without pull-up flips every cycle so it never reads as stable
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_level[i] = aux_oe[i] ? aux_out[i] : ext_en[i] ? ext_val[i] :
				aux_pull_up[i] ? 1'b1 : ~last[i];
		end
	end

	// Previous level, for the floating case
	always_ff @(posedge mclk) begin
		last <= pin_level;
	end
endmodule

`default_nettype wire

/* testbench/aux_pin_function_mux_bench.sv */
// Self-checking bench for the auxiliary pin function selector
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
	end \
end

module aux_pin_function_mux_bench
	import aux_mux_pkg::*;
;
	localparam logic [LED_CNT_W-1:0] PULSE = 24'h000008;
	logic mclk, rst;
	logic [7:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic uart_active, uart_tx_busy, tx_data_strobe, rx_data_strobe, usb_suspend;
	logic [NUM_PINS-1:0] aux_in, aux_out, aux_oe, aux_pull_up, ext_en, ext_val;
	logic [2*NUM_PINS-1:0] aux_drive;
	int num_errors, checks;

	aux_pin_function_mux #(.LED_PULSE(PULSE)) i_aux_pin_function_mux (
		.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .uart_active(uart_active),
		.uart_tx_busy(uart_tx_busy), .tx_data_strobe(tx_data_strobe),
		.rx_data_strobe(rx_data_strobe), .usb_suspend(usb_suspend), .aux_in(aux_in),
		.aux_out(aux_out), .aux_oe(aux_oe), .aux_pull_up(aux_pull_up),
		.aux_drive(aux_drive));

	aux_board_model i_aux_board_model (.mclk(mclk), .aux_out(aux_out), .aux_oe(aux_oe),
		.aux_pull_up(aux_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pin_level(aux_in));

	// One bus access; held until the rising edge that samples waitrequest low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			num_errors++;
			report_and_stop();
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic cfg(input int p, input logic [31:0] w);
		bus(1'b1, 8'(4 * p), w);
	endtask

	task automatic settle();
		repeat (3) @(negedge mclk);
	endtask

	// One-cycle activity strobe, then wait until the pin has reacted
	task automatic pulse(input logic tx);
		@(posedge mclk);
		tx_data_strobe <= tx;
		rx_data_strobe <= !tx;
		@(posedge mclk);
		tx_data_strobe <= 1'b0;
		rx_data_strobe <= 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic t_reset();
		@(negedge mclk);
		`CHK(aux_oe, 11'h000)
		`CHK(aux_pull_up, 11'h7ff)
		bus(1'b0, OFF_PIN_CFG, 32'h0);
		`CHK(rd, 32'h00000009)
		bus(1'b0, 8'h3c, 32'h0);
		`CHK(rd, 32'h00000000)
		$display("test reset done");
	endtask

	task automatic t_const();
		cfg(0, 32'h0a);
		cfg(1, 32'h0b);
		cfg(2, 32'h7a); // High, inverted, drive code 3
		settle();
		`CHK(aux_out[2:0], 3'b001)
		`CHK(aux_oe[2:0], 3'b111)
		`CHK(aux_drive[5:4], 2'b11)
		$display("test constant done");
	endtask

	task automatic t_status();
		cfg(4, 32'h01);
		cfg(5, 32'h05);
		cfg(6, 32'h00);
		for (int s = 0; s < 2; s++) begin
			@(posedge mclk);
			usb_suspend <= s[0];
			uart_tx_busy <= s[0];
			settle();
			`CHK(aux_out[6:4], {s[0], !s[0], s[0]})
			bus(1'b0, OFF_STATUS, 32'h0);
			`CHK(rd[2:0], {s[0], 1'b0, s[0]})
		end
		$display("test status done");
	endtask

	task automatic t_led();
		cfg(7, 32'h02);
		cfg(8, 32'h03);
		cfg(9, 32'h04);
		settle();
		`CHK(aux_out[9:7], 3'b111)
		pulse(1'b1);
		`CHK(aux_out[9:7], 3'b010)
		repeat (5) @(negedge mclk);
		`CHK(aux_out[9:7], 3'b010)
		repeat (8) @(negedge mclk);
		`CHK(aux_out[9:7], 3'b111)
		pulse(1'b0);
		`CHK(aux_out[9:7], 3'b001)
		$display("test activity done");
	endtask

	task automatic t_clock();
		int cnt[3];
		logic [2:0] prev;
		cfg(0, 32'h06);
		cfg(1, 32'h07);
		cfg(2, 32'h08);
		settle();
		cnt = '{0, 0, 0};
		prev = aux_out[2:0];
		repeat (200) begin
			@(negedge mclk);
			for (int c = 0; c < 3; c++)
				cnt[c] += int'(aux_out[c] != prev[c]);
			prev = aux_out[2:0];
		end
		// Each rate scaled to the fast clock's 60 toggles in 200 cycles
		for (int c = 0; c < 3; c++)
			`CHK((cnt[c] << c) inside {[56:64]}, 1'b1)
		$display("test clocks done");
	endtask

	task automatic t_gpio();
		for (int i = 0; i < NUM_PINS; i++)
			cfg(i, 32'h0c);
		bus(1'b1, OFF_GPIO_DIR, 32'h7ff);
		bus(1'b1, OFF_GPIO_OUT, 32'h2a5);
		settle();
		`CHK(aux_oe, 11'h7ff)
		`CHK(aux_out, 11'h2a5)
		@(posedge mclk);
		uart_active <= 1'b1;
		settle();
		`CHK(aux_oe, 11'h00f)
		`CHK(aux_pull_up[10:4], 7'h7f)
		@(posedge mclk);
		uart_active <= 1'b0;
		bus(1'b1, OFF_GPIO_DIR, 32'h0);
		@(posedge mclk);
		ext_en <= 11'h7ff;
		ext_val <= 11'h155;
		settle();
		bus(1'b0, OFF_GPIO_IN, 32'h0);
		`CHK(rd[10:0], 11'h155)
		$display("test gpio done");
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Main sequence
	initial begin
		num_errors = 0;
		checks = 0;
		rst = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		{uart_active, uart_tx_busy, tx_data_strobe, rx_data_strobe, usb_suspend} = 5'h00;
		ext_en = 11'h000;
		ext_val = 11'h000;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_const();
		t_status();
		t_led();
		t_clock();
		t_gpio();
		report_and_stop();
	end

	// Watchdog
	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
endmodule

`default_nettype wire
